// *** hbc_consts.svh ***
// register offsets, field positions and reset values of the breakpoint unit
`ifndef HBC_CONSTS_SVH
`define HBC_CONSTS_SVH
`define HBC_IDX_CTRL0      8'h20
`define HBC_IDX_CTRL1      8'h21
`define HBC_IDX_ADDR_HIGH  8'h22
`define HBC_IDX_ADDR_LOW   8'h23
`define HBC_IDX_DATA_HIGH  8'h24
`define HBC_IDX_DATA_LOW   8'h25
`define HBC_IDX_STATUS     8'h26
// control 0 fields
`define HBC_C0_MODE_HI     7
`define HBC_C0_MODE_LO     6
`define HBC_C0_PROG_ONLY   5
`define HBC_C0_SIZE_SEL    4
`define HBC_C0_SEC_RANGE   1
`define HBC_C0_FIRST_RANGE 0
// control 1 fields
`define HBC_C1_DATA_EN     6
`define HBC_C1_MASK_HIGH   5
`define HBC_C1_MASK_LOW    4
`define HBC_C1_SEC_DIR_EN  3
`define HBC_C1_SEC_DIR_VAL 2
`define HBC_C1_FIRST_DIR_EN  1
`define HBC_C1_FIRST_DIR_VAL 0
`define HBC_RESET_BYTE     8'h00
`endif

// *** hbc_pkg.sv ***
// types of the breakpoint unit
package hbc_pkg;
   typedef enum logic [3:0]
   {
      HBC_MODE_OFF      = 4'b0001,
      HBC_MODE_SWI_DUAL = 4'b0010,
      HBC_MODE_BDM_FULL = 4'b0100,
      HBC_MODE_BDM_DUAL = 4'b1000
   } hbc_mode_t;
   typedef enum logic [2:0]
   {
      HBC_BUS_IDLE  = 3'b001,
      HBC_BUS_WRITE = 3'b010,
      HBC_BUS_READ  = 3'b100
   } hbc_bus_state_t;
endpackage

// *** hbc_break_unit.sv ***
// hardware breakpoint comparator with AHB-Lite register slave
// ----------------------------------------------------------------------------
// What this block does
// - mode field: off, swi dual, full, bdm dual
// - bdm dual: each address break enters debug
// - dual modes: data enable gates second breakpoint
// - size select ignored in dual modes
// - debug entry only while debug enabled
// - no breaks while debug mode active
// - address pair on address; data pair per mode
// - program-only breaks only executed tagged opcodes
// - swi dual: program breaks only
// - second range: upper byte or full word
// - first range: upper byte or full word
// - data enable off: data pair unused
// - full mode high mask skips data high
// - full mode low mask skips data low
// - second direction compare: 0 write, 1 read
// - first direction compare: 0 write, 1 read
// - swi dual ignores all direction bits
// - swi dual uses fetch tagging, no data breaks
// - tag pins latched on bus clock fall
// ----------------------------------------------------------------------------
`timescale 1ns/1ps
`include "hbc_consts.svh"
module hbc_break_unit
   import hbc_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        resetn,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic        hready,
   input  wire logic [31:0] hwdata,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // cpu bus, same clock
   input  wire logic [15:0] cpu_addr,
   input  wire logic [15:0] cpu_data,
   input  wire logic        cpu_read,
   input  wire logic        cpu_cycle_valid,
   input  wire logic        cpu_opcode_fetch,
   input  wire logic        cpu_queue_head,
   input  wire logic        cpu_instr_boundary,
   // debug block, same clock
   input  wire logic        debug_enabled,
   input  wire logic        debug_active,
   input  wire logic        tag_enable,
   // tag pins, asynchronous, active low
   input  wire logic        tag_low_pin_n,
   input  wire logic        tag_high_pin_n,
   input  wire logic        bus_clock_e,
   // break requests
   output logic             swi_request,
   output logic             debug_request
);
   // ----------------------------------------------------------------------------
   // register slave
   // ----------------------------------------------------------------------------
   logic [7:0]  break_control_0_reg;
   logic [7:0]  break_control_1_reg;
   logic [7:0]  break_addr_high_reg;
   logic [7:0]  break_addr_low_reg;
   logic [7:0]  break_data_high_reg;
   logic [7:0]  break_data_low_reg;
   logic        wr_pend_reg;
   logic [7:0]  wr_idx_reg;
   logic [1:0]  pend_reg;
   logic [1:0]  pend_next;
   logic [1:0]  fetch_tag_reg;
   logic [1:0]  hit_cause_reg;

   // word index from byte address, misaligned bits dropped
   function automatic logic [7:0] word_index(input logic [31:0] a);
      word_index = a[9:2];
   endfunction

   wire logic access_ok = hsel & hready & htrans[1];

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         wr_pend_reg <= 1'b0;
      else
         wr_pend_reg <= access_ok & hwrite;
   end

   // index kept every cycle; only used while the pending flag is set
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         wr_idx_reg <= 8'h00;
      else
         wr_idx_reg <= word_index(haddr);
   end

   // each byte register sits in the low lane of its own word
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         break_control_0_reg <= `HBC_RESET_BYTE;
      else if (wr_pend_reg & (wr_idx_reg == `HBC_IDX_CTRL0))
         break_control_0_reg <= hwdata[7:0];
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         break_control_1_reg <= `HBC_RESET_BYTE;
      else if (wr_pend_reg & (wr_idx_reg == `HBC_IDX_CTRL1))
         break_control_1_reg <= hwdata[7:0];
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         break_addr_high_reg <= `HBC_RESET_BYTE;
      else if (wr_pend_reg & (wr_idx_reg == `HBC_IDX_ADDR_HIGH))
         break_addr_high_reg <= hwdata[7:0];
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         break_addr_low_reg <= `HBC_RESET_BYTE;
      else if (wr_pend_reg & (wr_idx_reg == `HBC_IDX_ADDR_LOW))
         break_addr_low_reg <= hwdata[7:0];
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         break_data_high_reg <= `HBC_RESET_BYTE;
      else if (wr_pend_reg & (wr_idx_reg == `HBC_IDX_DATA_HIGH))
         break_data_high_reg <= hwdata[7:0];
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         break_data_low_reg <= `HBC_RESET_BYTE;
      else if (wr_pend_reg & (wr_idx_reg == `HBC_IDX_DATA_LOW))
         break_data_low_reg <= hwdata[7:0];
   end

   // read data registered in the address phase: zero wait states
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         hrdata <= 32'h0000_0000;
      else if (access_ok & !hwrite)
      begin
         unique case (word_index(haddr))
            `HBC_IDX_CTRL0:     hrdata <= {24'h00_0000, break_control_0_reg};
            `HBC_IDX_CTRL1:     hrdata <= {24'h00_0000, break_control_1_reg};
            `HBC_IDX_ADDR_HIGH: hrdata <= {24'h00_0000, break_addr_high_reg};
            `HBC_IDX_ADDR_LOW:  hrdata <= {24'h00_0000, break_addr_low_reg};
            `HBC_IDX_DATA_HIGH: hrdata <= {24'h00_0000, break_data_high_reg};
            `HBC_IDX_DATA_LOW:  hrdata <= {24'h00_0000, break_data_low_reg};
            // status: pending flags, then cause of the last fired break, requested or not
            `HBC_IDX_STATUS:    hrdata <= {28'h000_0000, pend_reg, hit_cause_reg};
            default:            hrdata <= 32'h0000_0000;
         endcase
      end
   end

   // zero wait states: ready rises on the first edge after reset
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         hreadyout <= 1'b0;
      else
         hreadyout <= 1'b1;
   end

   // only okay responses
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         hresp <= 1'b0;
      else
         hresp <= 1'b0;
   end

   // ----------------------------------------------------------------------------
   // mode decode
   // ----------------------------------------------------------------------------
   // one-hot mode from the two mode bits
   hbc_mode_t mode;
   always_comb
   begin
      unique case ({break_control_0_reg[`HBC_C0_MODE_HI],
                    break_control_0_reg[`HBC_C0_MODE_LO]})
         2'b01:   mode = HBC_MODE_SWI_DUAL;
         2'b10:   mode = HBC_MODE_BDM_FULL;
         2'b11:   mode = HBC_MODE_BDM_DUAL;
         default: mode = HBC_MODE_OFF;
      endcase
   end

   wire logic dual      = (mode == HBC_MODE_SWI_DUAL) | (mode == HBC_MODE_BDM_DUAL);
   wire logic full      = (mode == HBC_MODE_BDM_FULL);
   wire logic swi_mode  = (mode == HBC_MODE_SWI_DUAL);
   // size select has no reader at all; dual modes never consult it
   wire logic prog_only = swi_mode | break_control_0_reg[`HBC_C0_PROG_ONLY];
   wire logic data_en   = break_control_1_reg[`HBC_C1_DATA_EN];

   // ----------------------------------------------------------------------------
   // comparators
   // ----------------------------------------------------------------------------
   // byte match of a 16-bit value, low byte optional
   function automatic logic word_match(input logic [15:0] v, input logic [7:0] hi,
                                       input logic [7:0] lo, input logic use_lo);
      word_match = (v[15:8] == hi) & (!use_lo | (v[7:0] == lo));
   endfunction

   function automatic logic dir_match(input logic en, input logic val, input logic rd);
      dir_match = !en | (val == rd);
   endfunction

   // direction bits are not used in swi dual mode
   wire logic dir0_ok = swi_mode | dir_match(break_control_1_reg[`HBC_C1_FIRST_DIR_EN],
                        break_control_1_reg[`HBC_C1_FIRST_DIR_VAL], cpu_read);
   wire logic dir1_ok = swi_mode | dir_match(break_control_1_reg[`HBC_C1_SEC_DIR_EN],
                        break_control_1_reg[`HBC_C1_SEC_DIR_VAL], cpu_read);

   wire logic [15:0] cmp_addr = cpu_addr;

   wire logic first_addr_hit = word_match(cmp_addr, break_addr_high_reg, break_addr_low_reg,
                               break_control_0_reg[`HBC_C0_FIRST_RANGE]);
   wire logic second_addr_hit = data_en & dual &
                                word_match(cmp_addr, break_data_high_reg, break_data_low_reg,
                                break_control_0_reg[`HBC_C0_SEC_RANGE]);
   wire logic data_hi_ok = break_control_1_reg[`HBC_C1_MASK_HIGH] |
                           (cpu_data[15:8] == break_data_high_reg);
   wire logic data_lo_ok = break_control_1_reg[`HBC_C1_MASK_LOW] |
                           (cpu_data[7:0] == break_data_low_reg);
   wire logic data_ok = !data_en | (data_hi_ok & data_lo_ok);

   // immediate hits on a live bus cycle; the two dual hits also feed the program-only fetch hit
   wire logic dual_hit0 = dual & first_addr_hit & dir0_ok;
   wire logic dual_hit1 = second_addr_hit & dir1_ok;
   wire logic full_hit  = full & first_addr_hit & dir0_ok & data_ok;

   // ----------------------------------------------------------------------------
   // tag pins
   // ----------------------------------------------------------------------------
   logic [2:0] tag_s1_reg;
   logic [2:0] tag_s2_reg;
   logic       e_prev_reg;
   logic [1:0] pin_tag_reg;

   // two flops on every asynchronous pin before any logic reads it
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         tag_s1_reg <= 3'h7;
         tag_s2_reg <= 3'h7;
      end
      else
      begin
         tag_s1_reg <= {bus_clock_e, tag_high_pin_n, tag_low_pin_n};
         tag_s2_reg <= tag_s1_reg;
      end
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         e_prev_reg <= 1'b0;
      else
         e_prev_reg <= tag_s2_reg[2];
   end

   // latch tags on the synchronised fall of the bus clock
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         pin_tag_reg <= 2'b00;
      else if (debug_active | !tag_enable)
         pin_tag_reg <= 2'b00;
      else if (e_prev_reg & !tag_s2_reg[2])
         pin_tag_reg <= ~tag_s2_reg[1:0];
   end

   // program-only hit judged on the fetch cycle itself, so a stale fetch
   // address cannot re-arm the tag after the queue head consumed it
   wire logic fetch_hit = prog_only & (dual_hit0 | dual_hit1 | (full & first_addr_hit));

   // one-deep tag tracking: the fetched opcode that matched, or a pin tag
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         fetch_tag_reg <= 2'b00;
      else if (cpu_cycle_valid & cpu_opcode_fetch)
         fetch_tag_reg <= {fetch_hit, |pin_tag_reg};
      else if (cpu_queue_head)
         fetch_tag_reg <= 2'b00;
      else
         fetch_tag_reg <= {fetch_tag_reg[1], |pin_tag_reg};
   end

   // ----------------------------------------------------------------------------
   // break requests
   // ----------------------------------------------------------------------------
   wire logic bus_hit = cpu_cycle_valid & !prog_only & (dual_hit0 | dual_hit1 | full_hit);
   wire logic tag_fire = cpu_queue_head & (|fetch_tag_reg);

   always_comb
   begin
      pend_next = pend_reg;
      if (debug_active)
         pend_next = 2'b00;
      else
      begin
         // set wins over the boundary clear, so a hit there is kept
         if (cpu_instr_boundary & pend_reg[0])
            pend_next[0] = 1'b0;
         if (bus_hit)
            pend_next[0] = 1'b1;
         if (tag_fire)
            pend_next[1] = 1'b1;
         else
            pend_next[1] = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         pend_reg <= 2'b00;
      else
         pend_reg <= pend_next;
   end

   // pending breaks are dropped, not delayed, while debug is active
   wire logic fire = !debug_active & ((cpu_instr_boundary & pend_reg[0]) | pend_reg[1]);

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         swi_request <= 1'b0;
      else
         swi_request <= fire & swi_mode & !(pend_reg[1] & fetch_tag_reg[0]);
   end

   // debug entry gated by the debug block's enable
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         debug_request <= 1'b0;
      else
         debug_request <= fire & debug_enabled &
                          (!swi_mode | (pend_reg[1] & fetch_tag_reg[0]));
   end

   // cause of the last fired break, also when debug disabled blocks the request, kept for the status word
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         hit_cause_reg <= 2'b00;
      else if (fire)
         hit_cause_reg <= {swi_mode, pend_reg[1]};
   end
endmodule // hbc_break_unit

// *** hbc_break_unit_assertions.sv ***
// port checks of the breakpoint unit
`timescale 1ns/1ps
`include "hbc_consts.svh"
// ------------------------------
// port checker
// ------------------------------
module hbc_checker
   import hbc_pkg::*;
(
   // clock and reset
   input wire logic        clk,
   input wire logic        resetn,
   // register bus
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic [31:0] hwdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   // cpu and debug
   input wire logic        cpu_queue_head,
   input wire logic        cpu_instr_boundary,
   input wire logic        debug_enabled,
   input wire logic        debug_active,
   // break requests
   input wire logic        swi_request,
   input wire logic        debug_request
);
   logic       wr_reg;
   logic [7:0] ctrl0_reg;
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   // shadow of control 0, seen only through bus writes
   always_ff @(posedge clk or negedge resetn)
      if (!resetn)
         wr_reg <= 1'b0;
      else if (hready)
         wr_reg <= hsel && htrans[1] && hwrite && haddr[9:2] == `HBC_IDX_CTRL0;
   always_ff @(posedge clk or negedge resetn)
      if (!resetn)
         ctrl0_reg <= 8'h00;
      else if (wr_reg && hready)
         ctrl0_reg <= hwdata[7:0];
   sequence req_s;
      swi_request || debug_request;
   endsequence
   sequence off_s;
      (ctrl0_reg[7:6] == 2'b00) [*4];
   endsequence
   off_quiet_a: assert property (off_s |-> not req_s)
      else $error("break request while off");
   swi_mode_a: assert property (swi_request |-> ctrl0_reg[7:6] == 2'b01)
      else $error("swi request outside swi mode");
   debug_mode_a: assert property (debug_request |-> ctrl0_reg[7])
      else $error("debug request outside debug modes");
   debug_enable_a: assert property (debug_request |-> $past(debug_enabled))
      else $error("debug request while debug disabled");
   active_block_a: assert property (debug_active [*2] |-> not req_s)
      else $error("break while debug active");
   req_cause_a: assert property (req_s |-> $past(cpu_instr_boundary)
      || $past(cpu_instr_boundary, 2) || $past(cpu_queue_head, 2)
      || $past(cpu_queue_head, 3))
      else $error("request without boundary or queue head");
   swi_pulse_a: assert property (swi_request |=> !swi_request)
      else $error("swi request longer than one cycle");
   debug_pulse_a: assert property (debug_request |=> !debug_request)
      else $error("debug request longer than one cycle");
   ready_high_a: assert property ($past(resetn) |-> hreadyout)
      else $error("wait state inserted");
   okay_resp_a: assert property (!hresp)
      else $error("error response");
endmodule // hbc_checker
bind hbc_break_unit hbc_checker i_chk (.clk, .resetn, .hsel, .haddr, .htrans, .hwrite,
   .hready, .hwdata, .hreadyout, .hresp, .cpu_queue_head, .cpu_instr_boundary,
   .debug_enabled, .debug_active, .swi_request, .debug_request);

// *** hbc_cpu_model.sv ***
// cpu bus model facing the breakpoint unit
`timescale 1ns/1ps
// ------------------------------
// cpu bus model
// ------------------------------
module hbc_cpu_model
(
   // clock
   input  wire logic        clk,
   // cpu bus
   output logic      [15:0] cpu_addr,
   output logic      [15:0] cpu_data,
   output logic             cpu_read,
   output logic             cpu_cycle_valid,
   output logic             cpu_opcode_fetch,
   output logic             cpu_queue_head,
   output logic             cpu_instr_boundary
);
   initial
   begin
      {cpu_addr, cpu_data} = 32'h0;
      {cpu_read, cpu_cycle_valid, cpu_opcode_fetch} = 3'h0;
      {cpu_queue_head, cpu_instr_boundary} = 2'h0;
   end
   // one cycle, idle gap, then boundary and queue head together
   task automatic cycle(input logic [15:0] a, input logic [15:0] d, input logic rd,
                        input logic fe, input int gap);
      @(posedge clk);
      {cpu_addr, cpu_data} <= {a, d};
      {cpu_read, cpu_cycle_valid, cpu_opcode_fetch} <= {rd, 1'b1, fe};
      @(posedge clk);
      // released bus shows inverted lines, never the held value
      {cpu_addr, cpu_data} <= {~a, ~d};
      {cpu_cycle_valid, cpu_opcode_fetch} <= 2'b00;
      repeat (gap) @(posedge clk);
      {cpu_queue_head, cpu_instr_boundary} <= 2'b11;
      @(posedge clk);
      {cpu_queue_head, cpu_instr_boundary} <= 2'b00;
   endtask
endmodule // hbc_cpu_model

// *** testbench.sv ***
// self-checking bench of the breakpoint unit
`timescale 1ns/1ps
`include "hbc_consts.svh"
// ------------------------------
// testbench
// ------------------------------
module testbench;
   logic        clk = 1'b0;
   logic        resetn = 1'b0;
   logic        hsel = 1'b0;
   logic        hwrite = 1'b0;
   logic        rd_ph = 1'b0;
   logic        debug_enabled = 1'b0;
   logic        debug_active = 1'b0;
   logic [1:0]  htrans = 2'b00;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic        hreadyout, hresp, swi_request, debug_request;
   logic        cpu_read, cpu_cycle_valid, cpu_opcode_fetch, cpu_queue_head;
   logic        cpu_instr_boundary;
   logic [15:0] cpu_addr, cpu_data;
   logic [1:0]  eq[$];
   logic [31:0] rq[$];
   int          seed = 54098;
   int          miscompares = 0;
   int          n_tests = 0;
   always #12.5 clk = ~clk;
   hbc_break_unit i_dut (.clk, .resetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'b010),
      .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp, .cpu_addr, .cpu_data,
      .cpu_read, .cpu_cycle_valid, .cpu_opcode_fetch, .cpu_queue_head, .cpu_instr_boundary,
      .debug_enabled, .debug_active, .tag_enable(1'b0), .tag_low_pin_n(1'b1),
      .tag_high_pin_n(1'b1), .bus_clock_e(1'b0), .swi_request, .debug_request);
   hbc_cpu_model i_cpu (.clk, .cpu_addr, .cpu_data, .cpu_read, .cpu_cycle_valid,
      .cpu_opcode_fetch, .cpu_queue_head, .cpu_instr_boundary);
   function automatic logic [7:0] r8();
      return 8'($random(seed));
   endfunction
   task automatic final_report();
      if (miscompares == 0 && n_tests > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cmp_req(input logic [1:0] got, input logic [1:0] exp);
      cmp_word({30'h0, got}, {30'h0, exp});
   endtask
   task automatic ahb(input logic w, input logic [7:0] idx, input logic [7:0] d);
      @(posedge clk);
      {hsel, htrans, hwrite, haddr} <= {3'b110, w, 22'h0, idx, 2'b00};
      do @(posedge clk); while (hreadyout !== 1'b1);
      {hsel, htrans, hwdata, rd_ph} <= {3'b000, 24'h0, d, !w};
      do @(posedge clk); while (hreadyout !== 1'b1);
      rd_ph <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] idx, input logic [7:0] e);
      rq.push_back({24'h0, e});
      ahb(1'b0, idx, 8'h00);
   endtask
   // f holds read, fetch, debug active, debug enabled, swi and debug expected
   task automatic run(input logic [15:0] cc, input logic [31:0] ad, input logic [15:0] ba,
                      input logic [15:0] bd, input logic [5:0] f);
      ahb(1'b1, `HBC_IDX_CTRL0, cc[15:8]);
      ahb(1'b1, `HBC_IDX_CTRL1, cc[7:0]);
      ahb(1'b1, `HBC_IDX_ADDR_HIGH, ad[31:24]);
      ahb(1'b1, `HBC_IDX_ADDR_LOW, ad[23:16]);
      ahb(1'b1, `HBC_IDX_DATA_HIGH, ad[15:8]);
      ahb(1'b1, `HBC_IDX_DATA_LOW, ad[7:0]);
      {debug_active, debug_enabled} <= f[3:2];
      if (f[1:0] != 2'b00)
         eq.push_back(f[1:0]);
      i_cpu.cycle(ba, bd, f[5], f[4], {$random(seed)} % 3);
      repeat (8) @(posedge clk);
      cmp_word(32'(eq.size()), 32'h0);
      debug_active <= 1'b0;
   endtask
   // results are taken off the queues as they appear
   always @(posedge clk)
   begin
      if (swi_request === 1'b1 || debug_request === 1'b1)
         cmp_req({swi_request, debug_request}, eq.size() > 0 ? eq.pop_front() : 2'b00);
      if (rd_ph && hreadyout === 1'b1)
         cmp_word(hrdata, rq.pop_front());
   end
   initial
   begin
      repeat (20) @(posedge clk);
      resetn <= 1'b1;
      repeat (2) @(posedge clk);
      for (int i = 32; i < 38; i++)
         rd(8'(i), 8'h00);
      ahb(1'b1, 8'h30, 8'h5a);
      rd(8'h30, 8'h00);
      run(16'h0000, 32'h12000000, {8'h12, r8()}, {2{r8()}}, 6'b110100);
      run(16'h4000, 32'h12000000, {8'h12, r8()}, {2{r8()}}, 6'b110110);
      run(16'h4100, 32'h12340000, 16'h1235, {2{r8()}}, 6'b110100);
      run(16'h404a, 32'hff005600, {8'h56, r8()}, {2{r8()}}, 6'b110110);
      run(16'h4000, 32'hff005600, {8'h56, r8()}, {2{r8()}}, 6'b110100);
      run(16'h4000, 32'h12000000, {8'h12, r8()}, {2{r8()}}, 6'b100100);
      run(16'h4240, 32'hff005678, 16'h5679, {2{r8()}}, 6'b110100);
      run(16'hc04c, 32'hff005600, {8'h56, r8()}, {2{r8()}}, 6'b000100);
      run(16'hc04c, 32'hff005600, {8'h56, r8()}, {2{r8()}}, 6'b100101);
      run(16'hc003, 32'h12000000, {8'h12, r8()}, {2{r8()}}, 6'b000100);
      run(16'hd002, 32'h12000000, {8'h12, r8()}, {2{r8()}}, 6'b000101);
      run(16'h8040, 32'h1200abcd, {8'h12, r8()}, 16'habcd, 6'b100101);
      run(16'h8040, 32'h1200abcd, {8'h12, r8()}, 16'habce, 6'b100100);
      run(16'h8050, 32'h1200abcd, {8'h12, r8()}, {8'hab, r8()}, 6'b100101);
      run(16'h8060, 32'h1200abcd, {8'h12, r8()}, {r8(), 8'hcd}, 6'b100101);
      run(16'h8060, 32'h1200abcd, {8'h12, r8()}, {r8(), 8'hce}, 6'b100100);
      run(16'h8040, 32'h1200abcd, {8'h12, r8()}, 16'habcd, 6'b100000);
      run(16'h8040, 32'h1200abcd, {8'h12, r8()}, 16'habcd, 6'b101100);
      run(16'he000, 32'h12000000, {8'h12, r8()}, {2{r8()}}, 6'b100100);
      run(16'he000, 32'h12000000, {8'h12, r8()}, {2{r8()}}, 6'b110101);
      rd(`HBC_IDX_STATUS, 8'h01);
      rd(`HBC_IDX_CTRL0, 8'he0);
      @(posedge clk);
      resetn <= 1'b0;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      repeat (2) @(posedge clk);
      rd(`HBC_IDX_CTRL0, 8'h00);
      final_report();
   end
   // watchdog against a hung handshake
   initial
   begin
      #100us;
      miscompares++;
      final_report();
   end
endmodule // testbench
